/* design/csp_cfg.svh */
// constants of the converter serial port
//
// Notes on behaviour
// - power-up reset loads known control word
// - mode high: port drives serial clock
// - select high reads output/calibration, low control
// - new conversion word drives ready low
// - ready returns high after last bit
// - unread words keep updating, ready stays low
// - word arriving mid output read lost
// - register reads ignore and keep ready
// - output read sync with ready high: nothing
// - register reads are exactly 24 bits
// - read sync fall starts clock, MSB out
// - bits shift on falling clock edges
// - after LSB fall: outputs off, ready high after output reads
// - writes are 24 bits, ignore ready
// - select routes write to control/calibration
// - write sync fall starts serial clock once write fifo has room
// - write data captured on rising, MSB first
// - clock off after final write fall
// - mode low: serial clock is input
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
`define CSP_WORD_W 24
`define CSP_CNT_W 5
`define CSP_WORD_BITS 5'h18
`define CSP_SHORT_BITS 5'h10
`define CSP_CTRL_RST 24'h000000
`define CSP_CTRL_WL24 0
`define CSP_CTRL_CALRD 1
`define CSP_CLK_NS 40
`define CSP_SCLK_HALF_NS 160
`define CSP_DIV_W 8
`define CSP_FIFO_DEPTH 16
`endif

/* design/csp_pkg.sv */
// types of the converter serial port
`include "csp_cfg.svh"
package csp_pkg;
  typedef enum logic {CSP_IDLE, CSP_XFER} csp_state_t;
  typedef enum logic [1:0] {CSP_K_OUT, CSP_K_REG, CSP_K_WR} csp_kind_t;
  typedef struct packed {
    logic sel;
    logic [`CSP_WORD_W-1:0] data;
  } csp_wr_t;
endpackage : csp_pkg

/* design/csp_port.sv */
// converter serial port with write fifo
`timescale 1ns/1ps
`include "csp_cfg.svh"

// ----------------------------------------
// fifo of written words
// ----------------------------------------
module csp_fifo #(
  parameter int W = 25,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } csp_fifo_st_t;
  csp_fifo_st_t q, n;
  logic push, pop;

  assign in_ready = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];

  always_comb begin
    n = q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
    end
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule : csp_fifo

// ----------------------------------------
// serial port
// ----------------------------------------
module csp_port
  import csp_pkg::*;
#(
  parameter int SCLK_HALF_CYC =
    (`CSP_SCLK_HALF_NS + `CSP_CLK_NS - 1) / `CSP_CLK_NS,
  parameter int FIFO_DEPTH = `CSP_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic mode_select,
  input wire logic read_frame_sync_n,
  input wire logic write_frame_sync_n,
  input wire logic register_select,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  output logic conversion_ready_n,
  input wire logic conv_strobe,
  input wire logic [`CSP_WORD_W-1:0] conv_data,
  input wire logic [`CSP_WORD_W-1:0] cal_rd_data,
  output logic [`CSP_WORD_W-1:0] ctrl_word,
  output logic cal_wr_valid,
  input wire logic cal_wr_ready,
  output logic [`CSP_WORD_W-1:0] cal_wr_data
);
  typedef struct packed {
    logic [1:0] mode_s;
    logic [1:0] rfs_s;
    logic [1:0] tfs_s;
    logic [1:0] sel_s;
    logic [1:0] sdi_s;
    logic [1:0] sck_s;
    logic rfs_p;
    logic tfs_p;
    logic sck_p;
    logic wr_pend;
    csp_state_t st;
    csp_kind_t kind;
    logic [`CSP_DIV_W-1:0] div;
    logic [`CSP_CNT_W-1:0] bits;
    logic [`CSP_WORD_W-1:0] sh;
    logic [`CSP_WORD_W-1:0] outw;
    logic [`CSP_WORD_W-1:0] ctrl;
    logic rdy_n;
    logic sck;
    logic sck_oe;
    logic sd_oe;
    logic push;
    csp_wr_t wdata;
  } csp_st_t;

  csp_st_t q, n;
  logic master, rfs_fall, tfs_fall, rise, fall, tick, fin, out_busy;
  logic fifo_in_ready, fifo_valid, fifo_ready;
  csp_wr_t fifo_head;

  // ----------------------------------------
  // write fifo and its drain
  // ----------------------------------------
  csp_fifo #(
    .W($bits(csp_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(q.push),
    .in_ready(fifo_in_ready),
    .in_data(q.wdata),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_head)
  );

  // control words are taken at once, calibration words wait on the core
  assign fifo_ready = fifo_head.sel ? cal_wr_ready : 1'b1;
  assign cal_wr_valid = fifo_valid && fifo_head.sel;
  assign cal_wr_data = fifo_head.data;

  assign sclk_o = q.sck;
  assign sclk_oe = q.sck_oe;
  assign serial_data_line_o = q.sh[`CSP_WORD_W-1];
  assign serial_data_line_oe = q.sd_oe;
  assign conversion_ready_n = q.rdy_n;
  assign ctrl_word = q.ctrl;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = q;
    n.push = 1'b0;
    n.mode_s = {q.mode_s[0], mode_select};
    n.rfs_s = {q.rfs_s[0], read_frame_sync_n};
    n.tfs_s = {q.tfs_s[0], write_frame_sync_n};
    n.sel_s = {q.sel_s[0], register_select};
    n.sdi_s = {q.sdi_s[0], serial_data_line_i};
    n.sck_s = {q.sck_s[0], sclk_i};
    n.rfs_p = q.rfs_s[1];
    n.tfs_p = q.tfs_s[1];
    n.sck_p = q.sck_s[1];
    master = q.mode_s[1];
    rfs_fall = q.rfs_p && !q.rfs_s[1];
    tfs_fall = q.tfs_p && !q.tfs_s[1];
    out_busy = (q.st == CSP_XFER) && (q.kind == CSP_K_OUT);
    tick = (q.st == CSP_XFER) && (q.div == `CSP_DIV_W'(SCLK_HALF_CYC - 1));
    rise = master ? (tick && !q.sck) : (!q.sck_p && q.sck_s[1]);
    fall = master ? (tick && q.sck) : (q.sck_p && !q.sck_s[1]);
    fin = 1'b0;
    if (q.tfs_s[1]) begin
      n.wr_pend = 1'b0;
    end else if (tfs_fall) begin
      n.wr_pend = 1'b1;
    end
    if (fifo_valid && !fifo_head.sel) begin
      n.ctrl = fifo_head.data;
    end
    // a word landing during an output read is dropped
    if (conv_strobe && !out_busy) begin
      n.outw = conv_data;
      n.rdy_n = 1'b0;
    end
    unique case (q.st)
      CSP_IDLE: begin
        n.div = '0;
        n.sck = 1'b0;
        n.sck_oe = 1'b0;
        n.sd_oe = 1'b0;
        if (rfs_fall && q.tfs_s[1]) begin
          n.bits = `CSP_WORD_BITS;
          n.kind = CSP_K_REG;
          if (!q.sel_s[1]) begin
            n.sh = q.ctrl;
            n.st = CSP_XFER;
          end else if (q.ctrl[`CSP_CTRL_CALRD]) begin
            n.sh = cal_rd_data;
            n.st = CSP_XFER;
          end else if (!q.rdy_n) begin
            n.sh = q.outw;
            n.kind = CSP_K_OUT;
            n.st = CSP_XFER;
            if (!q.ctrl[`CSP_CTRL_WL24]) begin
              n.bits = `CSP_SHORT_BITS;
            end
          end
          n.sck_oe = master && (n.st == CSP_XFER);
          n.sd_oe = (n.st == CSP_XFER);
        end else if (q.wr_pend && fifo_in_ready) begin
          n.wr_pend = 1'b0;
          n.kind = CSP_K_WR;
          n.bits = `CSP_WORD_BITS;
          n.wdata.sel = q.sel_s[1];
          n.sck_oe = master;
          n.st = CSP_XFER;
        end
      end
      CSP_XFER: begin
        n.div = tick ? '0 : q.div + 1'b1;
        if (master && tick) begin
          n.sck = !q.sck;
        end
        if (rise) begin
          n.bits = q.bits - 1'b1;
          if (q.kind == CSP_K_WR) begin
            n.sh = {q.sh[`CSP_WORD_W-2:0], q.sdi_s[1]};
          end
        end
        if (fall) begin
          if (q.bits == '0) begin
            fin = 1'b1;
          end else if (q.kind != CSP_K_WR) begin
            n.sh = {q.sh[`CSP_WORD_W-2:0], 1'b0};
          end
        end
        if (fin) begin
          n.st = CSP_IDLE;
          n.sck_oe = 1'b0;
          n.sd_oe = 1'b0;
          n.sck = 1'b0;
          if (q.kind == CSP_K_OUT) begin
            n.rdy_n = 1'b1;
          end
          if (q.kind == CSP_K_WR) begin
            n.push = 1'b1;
            n.wdata.data = q.sh;
          end
        end
        // a frame sync released mid-word abandons the word
        if ((q.kind == CSP_K_WR) ? q.tfs_s[1] : q.rfs_s[1]) begin
          n.st = CSP_IDLE;
          n.sck_oe = 1'b0;
          n.sd_oe = 1'b0;
          n.sck = 1'b0;
          n.push = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      q <= '0;
      q.rfs_s <= 2'h3;
      q.tfs_s <= 2'h3;
      q.rfs_p <= 1'b1;
      q.tfs_p <= 1'b1;
      q.rdy_n <= 1'b1;
      q.ctrl <= `CSP_CTRL_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_ctrl_reset: assert property ($rose(rst_b) |-> q.ctrl == `CSP_CTRL_RST)
    else $error("control word not at reset value");
  chk_master_clock: assert property (
    (q.st == CSP_XFER && q.mode_s[1] && $stable(q.st)) |-> sclk_oe)
    else $error("master transfer without driven clock");
  chk_slave_input: assert property (!q.mode_s[1] |-> !sclk_oe)
    else $error("clock driven in slave mode");
  chk_ready_falls: assert property (
    (conv_strobe && !out_busy) |=> !conversion_ready_n)
    else $error("new word did not lower ready");
  chk_lost_word: assert property (
    (conv_strobe && out_busy) |=> $stable(q.outw))
    else $error("word stored during output read");
  chk_no_out_read: assert property (
    (q.st == CSP_IDLE && rfs_fall && q.tfs_s[1] && q.sel_s[1] &&
     !q.ctrl[`CSP_CTRL_CALRD] && q.rdy_n) |=> q.st == CSP_IDLE)
    else $error("output read started with ready high");
  chk_reg_len: assert property (
    (q.st == CSP_IDLE && n.st == CSP_XFER && n.kind != CSP_K_OUT)
      |=> q.bits == `CSP_WORD_BITS)
    else $error("register transfer not 24 bits");
  chk_out_end: assert property ((fin && q.kind == CSP_K_OUT) |=>
    (conversion_ready_n && !sclk_oe && !serial_data_line_oe))
    else $error("output read end did not release port");
  chk_reg_ready: assert property (
    (q.st == CSP_XFER && q.kind != CSP_K_OUT && !conv_strobe)
      |=> $stable(conversion_ready_n))
    else $error("register transfer moved ready");
  chk_wr_off: assert property ((fin && q.kind == CSP_K_WR) |=>
    (!sclk_oe && q.push && q.wdata.data == $past(q.sh)))
    else $error("write end did not stop clock or store word");
endmodule : csp_port

/* verif/csp_host_model.sv */
// host partner model: frame syncs, select and write data for the port
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_host_model (
  input wire logic clk_sys,
  input wire logic sclk,
  input wire logic sd,
  input wire logic ext,
  output logic hck,
  output logic rfs_n,
  output logic wfs_n,
  output logic sel,
  output logic hd,
  output logic rd_stb,
  output logic [`CSP_WORD_W-1:0] rd_word
);
  initial begin
    rfs_n = 1'b1;
    wfs_n = 1'b1;
    sel = 1'b0;
    hd = 1'b0;
    hck = 1'b0;
    rd_stb = 1'b0;
    rd_word = 24'h000000;
  end

  // ----------------------------------------
  // one framed transfer, ok low if no clock came
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic s, input int len,
    input logic [`CSP_WORD_W-1:0] wd, output logic ok);
    int n;
    int t;
    logic last;
    n = 0;
    t = 0;
    last = sclk;
    @(negedge clk_sys);
    rd_word = 24'h000000;
    sel = s;
    if (wr) begin
      wfs_n = 1'b0;
      hd = wd[23];
    end else begin
      rfs_n = 1'b0;
    end
    while (n < len && t < 40 + len * 9) begin
      @(negedge clk_sys);
      t++;
      if (sclk && !last) begin
        rd_word = {rd_word[22:0], sd};
        n++;
      end else if (!sclk && last && wr && n > 0 && n < len) begin
        hd = wd[23-n];
      end
      last = sclk;
      // a slave-mode frame gets its clock from here, 8 clk per bit
      if (ext && t >= 8 && t % 4 == 0) begin
        hck = ~hck;
      end
    end
    // closing fall of a slave-mode frame after its last high phase
    if (ext) begin
      repeat (3) @(negedge clk_sys);
      hck = 1'b0;
    end
    // sync held low until the closing fall
    while (sclk && t < 400) begin
      @(negedge clk_sys);
      t++;
    end
    repeat (3) @(negedge clk_sys);
    rfs_n = 1'b1;
    wfs_n = 1'b1;
    hd = ~hd;
    ok = (n == len);
    if (ok && !wr) begin
      rd_stb = 1'b1;
      @(negedge clk_sys);
      rd_stb = 1'b0;
    end
  endtask : xfer
endmodule : csp_host_model

/* verif/test_csp_port.sv */
// self-checking testbench of the converter serial port
`timescale 1ns/1ps
`include "csp_cfg.svh"
module test_csp_port;
  import csp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic mode = 1'b1;
  logic conv_strobe = 1'b0;
  logic [23:0] conv_data = 24'h000000;
  logic [23:0] cal_rd_data = 24'h000000;
  logic cal_wr_ready = 1'b1;
  logic sclk_o, sclk_oe, sd_o, sd_oe, ready_n, cal_wr_valid;
  logic rfs_n, wfs_n, sel, hd, rd_stb, ok, hck;
  logic [23:0] ctrl_word, cal_wr_data, rd_word, ctrl_p, got, w, cw;
  logic [23:0] exp_q[$];
  int num_errors = 0;
  int tests_run = 0;
  // pull-up on the clock line in master mode, host clock in slave mode
  wire sclk = sclk_oe ? sclk_o : (mode ? 1'b1 : hck);
  wire sd = sd_oe ? sd_o : hd;

  always #20 clk_sys = ~clk_sys;

  csp_port dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .mode_select(mode),
    .read_frame_sync_n(rfs_n), .write_frame_sync_n(wfs_n),
    .register_select(sel), .sclk_i(sclk), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .serial_data_line_i(sd), .serial_data_line_o(sd_o),
    .serial_data_line_oe(sd_oe), .conversion_ready_n(ready_n),
    .conv_strobe(conv_strobe), .conv_data(conv_data),
    .cal_rd_data(cal_rd_data), .ctrl_word(ctrl_word),
    .cal_wr_valid(cal_wr_valid), .cal_wr_ready(cal_wr_ready),
    .cal_wr_data(cal_wr_data));

  csp_host_model host_u (.clk_sys(clk_sys), .sclk(sclk), .sd(sd),
    .ext(!mode), .hck(hck),
    .rfs_n(rfs_n), .wfs_n(wfs_n), .sel(sel), .hd(hd), .rd_stb(rd_stb),
    .rd_word(rd_word));

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic strobe(input logic [23:0] d);
    @(negedge clk_sys);
    conv_strobe = 1'b1;
    conv_data = d;
    @(negedge clk_sys);
    conv_strobe = 1'b0;
  endtask : strobe

  task automatic wrap_up;
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // result monitor: oldest note against each word seen
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst_b && (rd_stb || (cal_wr_valid && cal_wr_ready) ||
        ctrl_word !== ctrl_p)) begin
      got = rd_stb ? rd_word : (cal_wr_valid ? cal_wr_data : ctrl_word);
      if (exp_q.size() == 0) begin
        chk(got, ~got);
      end else begin
        chk(got, exp_q.pop_front());
      end
    end
    ctrl_p = ctrl_word;
  end

  initial begin
    #(40 * 20000);
    num_errors++;
    wrap_up();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hD66F));
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({23'h000000, ready_n}, 24'h000001);
    chk(ctrl_word, 24'h000000);
    host_u.xfer(1'b0, 1'b1, 24, 24'h000000, ok);
    chk({23'h000000, ok}, 24'h000000);
    w = {$urandom} & 24'hFFFFFC | 24'h000001;
    cw = w;
    exp_q.push_back(w);
    host_u.xfer(1'b1, 1'b0, 24, w, ok);
    chk({23'h000000, ready_n}, 24'h000001);
    strobe($urandom);
    chk({23'h000000, ready_n}, 24'h000000);
    w = $urandom;
    strobe(w);
    exp_q.push_back(w);
    fork
      host_u.xfer(1'b0, 1'b1, 24, 24'h000000, ok);
      begin
        repeat (60) @(negedge clk_sys);
        strobe($urandom);
      end
    join
    chk({23'h000000, ready_n}, 24'h000001);
    strobe(w);
    exp_q.push_back(cw);
    host_u.xfer(1'b0, 1'b0, 24, 24'h000000, ok);
    chk({23'h000000, ready_n}, 24'h000000);
    exp_q.push_back(24'h000000);
    host_u.xfer(1'b1, 1'b0, 24, 24'h000000, ok);
    exp_q.push_back({8'h00, w[23:8]});
    host_u.xfer(1'b0, 1'b1, 16, 24'h000000, ok);
    chk({23'h000000, ready_n}, 24'h000001);
    exp_q.push_back(24'h000002);
    host_u.xfer(1'b1, 1'b0, 24, 24'h000002, ok);
    cal_rd_data = $urandom;
    exp_q.push_back(cal_rd_data);
    host_u.xfer(1'b0, 1'b1, 24, 24'h000000, ok);
    cal_wr_ready = 1'b0;
    for (int i = 0; i < 17; i++) begin
      w = $urandom;
      if (i < 16) exp_q.push_back(w);
      host_u.xfer(1'b1, 1'b1, 24, w, ok);
      chk({23'h000000, ok}, (i < 16) ? 24'h000001 : 24'h000000);
    end
    repeat (60) begin
      @(negedge clk_sys);
      cal_wr_ready = $urandom;
    end
    cal_wr_ready = 1'b1;
    repeat (40) @(negedge clk_sys);
    // slave mode: the host makes the serial clock
    mode = 1'b0;
    repeat (4) @(negedge clk_sys);
    w = {$urandom} & 24'hFFFFFC | 24'h000001;
    cw = w;
    exp_q.push_back(cw);
    host_u.xfer(1'b1, 1'b0, 24, w, ok);
    exp_q.push_back(cw);
    host_u.xfer(1'b0, 1'b0, 24, 24'h000000, ok);
    w = $urandom;
    strobe(w);
    exp_q.push_back(w);
    host_u.xfer(1'b0, 1'b1, 24, 24'h000000, ok);
    chk({23'h000000, ready_n}, 24'h000001);
    repeat (4) @(negedge clk_sys);
    chk(exp_q.size(), 24'h000000);
    wrap_up();
  end
endmodule : test_csp_port
